// ---- adcst_pkg.sv ----
// Constants, register map and types for the converter status block
// =====================================================================
package adcst_pkg;

  // =====================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] ADCST_IDX_STATUS   = 8'h06;
  localparam logic [7:0] ADCST_IDX_TEST0    = 8'h08;
  localparam logic [7:0] ADCST_IDX_TEST1    = 8'h09;
  localparam logic [7:0] ADCST_IDX_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADCST_IDX_IRQ_MASK = 8'h11;
  localparam logic [7:0] ADCST_IDX_CONFIG   = 8'h12;

  // =====================================================================
  // Field positions
  localparam int ADCST_BIT_SEQ_DONE    = 7;
  localparam int ADCST_BIT_TRIG_OVR    = 5;
  localparam int ADCST_BIT_RES_OVR     = 4;
  localparam int ADCST_BIT_SPECIAL_EN  = 0;
  localparam int ADCST_BIT_FAST_CLEAR  = 0;
  localparam int ADCST_BIT_TRIG_LEVEL  = 1;
  localparam int ADCST_BIT_QUEUE_MODE  = 2;
  localparam int ADCST_IRQ_SEQ_DONE    = 0;
  localparam int ADCST_IRQ_TRIG_OVR    = 1;
  localparam int ADCST_IRQ_RES_OVR     = 2;

  // =====================================================================
  // Reset values
  localparam logic [7:0]  ADCST_RST_BYTE = 8'h00;
  localparam logic [3:0]  ADCST_RST_CNT  = 4'h0;
  localparam logic [2:0]  ADCST_RST_IRQ  = 3'h0;
  localparam logic [31:0] ADCST_RST_WORD = 32'h0000_0000;

  // =====================================================================
  // Special channel codes
  localparam logic [3:0] ADCST_CODE_VRH = 4'h4;
  localparam logic [3:0] ADCST_CODE_VRL = 4'h5;
  localparam logic [3:0] ADCST_CODE_MID = 4'h6;

  // Source picked for the analog path
  typedef enum logic [2:0] {
    ADCST_SRC_EXTERNAL = 3'b000,
    ADCST_SRC_VRH      = 3'b001,
    ADCST_SRC_VRL      = 3'b010,
    ADCST_SRC_MID      = 3'b011,
    ADCST_SRC_RESERVED = 3'b100
  } adcst_src_type;

endpackage

// ---- adcst_status_regs.sv ----
// Status and test registers of the converter sequence controller
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module adcst_status_regs
  import adcst_pkg::*;
#(
  parameter int CNT_W = 4                    // Conversion counter width
) (
  input  wire logic              clk_sys_i,       // 200 MHz system clock
  input  wire logic              resetn_i,        // Synchronous, low
  // APB slave
  input  wire logic              psel_i,          // Select
  input  wire logic              penable_i,       // Access phase
  input  wire logic              pwrite_i,        // Write direction
  input  wire logic [11:0]       paddr_i,         // Byte address
  input  wire logic [31:0]       pwdata_i,        // Write data
  output logic                   pready_o,        // Always ready
  output logic                   pslverr_o,       // Unmapped address
  output logic [31:0]            prdata_o,        // Read data
  // Sequence controller events, same clock
  input  wire logic              seq_start_trig_i,  // Trigger started seq
  input  wire logic              seq_end_i,         // Sequence finished
  input  wire logic              seq_active_i,      // Sequence in progress
  input  wire logic              trig_edge_i,       // Active trigger edge
  input  wire logic              result_write_i,    // Result reg written
  input  wire logic              result_ccf_set_i,  // Its done flag set
  input  wire logic              result_read_i,     // Result reg read
  input  wire logic              ctrl_abort_wr_i,   // Write ctrl regs 0..4
  input  wire logic              ctrl_start_wr_i,   // Write start ctrl reg
  input  wire logic [3:0]        chan_sel_i,        // Channel select code
  // Chip mode pin, asynchronous
  input  wire logic              special_mode_i,    // Special test mode
  // Outputs
  output logic [CNT_W-1:0]       conversion_counter_o,    // Result index
  output logic                   special_channel_enable_o, // Test enable
  output logic                   fast_flag_clear_o,       // Config bit
  output logic                   trigger_level_select_o,  // Config bit
  output logic                   queue_mode_o,            // Config bit
  output adcst_src_type          chan_src_o,              // Decoded source
  output logic [7:0]             test0_o,                 // Test0 contents
  output logic                   irq_o                    // Interrupt
);

  // =====================================================================
  // Declarations
  // Flags and counter
  logic             sequence_done_flag_r;   // Status bit 7
  logic             trigger_overrun_flag_r; // Status bit 5
  logic             result_overrun_flag_r;  // Status bit 4
  logic [CNT_W-1:0] conv_cnt_r;             // Conversion counter
  // Test and config registers
  logic [7:0]       test0_r;                // Reserved test register
  logic             special_en_r;           // Test1 bit 0
  logic [4:0]       test1_spare_r;          // Test1 bits 5:1
  logic [2:0]       config_r;               // Fast clear, level, queue
  // Interrupt bits
  logic [2:0]       irq_stat_r;             // Sticky event bits
  logic [2:0]       irq_mask_r;             // Event enables
  logic [2:0]       irq_stat_nxt;           // Next sticky bits
  // Mode synchroniser
  logic             mode_sync1_r;           // Synchroniser stage one
  logic             mode_sync2_r;           // Synchronised special mode
  // Bus decode terms
  logic             wr_en;                  // Write taken this edge
  logic             rd_setup;               // Read setup cycle
  logic [7:0]       widx;                   // Word index of address
  logic             mapped;                 // Address hits a register
  // Sequence event decode
  logic             start_any;              // Any sequence start
  logic             set_seq_done;           // Done event
  logic             set_trig_ovr;           // Trigger overrun event
  logic             set_res_ovr;            // Result overrun event
  // Read path
  logic [31:0]      rd_word;                // Read mux

  // Decode whether a word index is a register of this block
  // Shared by error response and read mux
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == ADCST_IDX_STATUS)   || (idx == ADCST_IDX_TEST0) ||
                 (idx == ADCST_IDX_TEST1)    ||
                 (idx == ADCST_IDX_IRQ_STAT) ||
                 (idx == ADCST_IDX_IRQ_MASK) || (idx == ADCST_IDX_CONFIG);
  endfunction

  // Write strobe for a given register index
  // All writes and W1C clears use it
  function automatic logic wr_hit(input logic wen, input logic [7:0] a,
                                  input logic [7:0] idx);
    wr_hit = wen && (a == idx);
  endfunction

  // =====================================================================
  // Bus decode
  // Misaligned or out-of-window accesses
  // get an error and read zero
  // Upper address bits above the word index must be zero to hit
  assign widx     = {paddr_i[9:2]};
  assign mapped   = idx_mapped(widx) && (paddr_i[11:10] == 2'b00) &&
                    (paddr_i[1:0] == 2'b00);
  // Zero wait states: a write lands at the access edge
  // pready is tied high: one-cycle access
  assign wr_en    = psel_i && penable_i && pwrite_i && mapped;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Event terms
  // Pulses from logic on this clock: no
  // synchroniser, they act at the edge they are high
  assign start_any    = ctrl_start_wr_i || seq_start_trig_i;
  assign set_seq_done = seq_end_i;
  // Only edge mode counts extra edges as overruns
  assign set_trig_ovr = trig_edge_i && seq_active_i &&
                        !config_r[ADCST_BIT_TRIG_LEVEL];
  assign set_res_ovr  = result_write_i && result_ccf_set_i;

  // =====================================================================
  // Special mode pin synchroniser
  // Async pin: two flops buy safety from
  // metastability for two cycles of lag
  // Stage one feeds only stage two
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode_sync1_r <= 1'b0;
      mode_sync2_r <= 1'b0;
    end else begin
      mode_sync1_r <= special_mode_i;
      mode_sync2_r <= mode_sync1_r;
    end
  end

  // =====================================================================
  // Sequence done flag
  // Setting wins over every clear in the same cycle
  // so a completion never loses to a clear
  // Fast clear lets a result read clear it
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sequence_done_flag_r <= 1'b0;
    end else if (set_seq_done) begin
      sequence_done_flag_r <= 1'b1;
    end else if ((wr_hit(wr_en, widx, ADCST_IDX_STATUS) &&
                  pwdata_i[ADCST_BIT_SEQ_DONE]) ||
                 ctrl_start_wr_i ||
                 (config_r[ADCST_BIT_FAST_CLEAR] && result_read_i)) begin
      sequence_done_flag_r <= 1'b0;
    end
  end

  // =====================================================================
  // Trigger overrun flag
  // Control writes 0 to 4 abort the sequence,
  // so an old overrun no longer means anything
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      trigger_overrun_flag_r <= 1'b0;
    end else if (set_trig_ovr) begin
      trigger_overrun_flag_r <= 1'b1;
    end else if ((wr_hit(wr_en, widx, ADCST_IDX_STATUS) &&
                  pwdata_i[ADCST_BIT_TRIG_OVR]) ||
                 ctrl_abort_wr_i || ctrl_start_wr_i) begin
      trigger_overrun_flag_r <= 1'b0;
    end
  end

  // =====================================================================
  // Result overrun flag
  // A start by write or trigger clears it;
  // a same-cycle overwrite still wins
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      result_overrun_flag_r <= 1'b0;
    end else if (set_res_ovr) begin
      result_overrun_flag_r <= 1'b1;
    end else if ((wr_hit(wr_en, widx, ADCST_IDX_STATUS) &&
                  pwdata_i[ADCST_BIT_RES_OVR]) || start_any) begin
      result_overrun_flag_r <= 1'b0;
    end
  end

  // =====================================================================
  // Conversion counter
  // Software status writes never reach this process
  // Control write beats sequence bounds,
  // which beat a result write outside queue mode: the count
  // restarts, so that write is not counted
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      conv_cnt_r <= CNT_W'(ADCST_RST_CNT);
    end else if (ctrl_abort_wr_i || ctrl_start_wr_i) begin
      // Control writes clear it even in queue mode
      conv_cnt_r <= '0;
    end else if ((seq_start_trig_i || seq_end_i) &&
                 !config_r[ADCST_BIT_QUEUE_MODE]) begin
      conv_cnt_r <= '0;
    end else if (result_write_i) begin
      // Natural binary wrap past the maximum
      conv_cnt_r <= conv_cnt_r + CNT_W'(1);
    end
  end
  // Counter goes out straight from its flop
  assign conversion_counter_o = conv_cnt_r;

  // =====================================================================
  // Reserved test register
  // Writes outside special modes are dropped silently
  // Only the synchronised mode is read, so a
  // racing write is kept whole or dropped
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      test0_r <= ADCST_RST_BYTE;
    end else if (wr_hit(wr_en, widx, ADCST_IDX_TEST0) && mode_sync2_r) begin
      test0_r <= pwdata_i[7:0];
    end
  end
  // Contents visible to the test hooks
  assign test0_o = test0_r;

  // =====================================================================
  // Second test register, writable at any time
  // Bit 0 enables special channels; bits 5:1
  // read back as written, bits 7:6 unstored
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      special_en_r  <= 1'b0;
      test1_spare_r <= 5'h00;
    end else if (wr_hit(wr_en, widx, ADCST_IDX_TEST1)) begin
      special_en_r  <= pwdata_i[ADCST_BIT_SPECIAL_EN];
      test1_spare_r <= pwdata_i[5:1];
    end
  end
  // Enable drives the decode and the pin
  assign special_channel_enable_o = special_en_r;

  // =====================================================================
  // Channel source decode
  // Three special codes name a source; the
  // rest report reserved so the analog path
  // can refuse them. Disabled: all external.
  always_comb begin
    chan_src_o = ADCST_SRC_EXTERNAL;
    if (special_en_r) begin
      case (chan_sel_i)
        ADCST_CODE_VRH: chan_src_o = ADCST_SRC_VRH;
        ADCST_CODE_VRL: chan_src_o = ADCST_SRC_VRL;
        ADCST_CODE_MID: chan_src_o = ADCST_SRC_MID;
        default:        chan_src_o = ADCST_SRC_RESERVED;
      endcase
    end
  end

  // =====================================================================
  // Configuration register
  // Own: bit 0 fast clear, bit 1 level
  // trigger, bit 2 queue; rest ignored
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      config_r <= 3'h0;
    end else if (wr_hit(wr_en, widx, ADCST_IDX_CONFIG)) begin
      config_r <= pwdata_i[2:0];
    end
  end
  // Config bits go out as plain levels
  assign fast_flag_clear_o      = config_r[ADCST_BIT_FAST_CLEAR];
  assign trigger_level_select_o = config_r[ADCST_BIT_TRIG_LEVEL];
  assign queue_mode_o           = config_r[ADCST_BIT_QUEUE_MODE];

  // =====================================================================
  // Interrupt status and mask
  // Each flag event also sets a sticky bit;
  // writing a one clears it
  // New events are ORed in after the clear so a set is never lost
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_hit(wr_en, widx, ADCST_IDX_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~pwdata_i[2:0];
    end
    irq_stat_nxt[ADCST_IRQ_SEQ_DONE] = irq_stat_nxt[ADCST_IRQ_SEQ_DONE] |
                                       set_seq_done;
    irq_stat_nxt[ADCST_IRQ_TRIG_OVR] = irq_stat_nxt[ADCST_IRQ_TRIG_OVR] |
                                       set_trig_ovr;
    irq_stat_nxt[ADCST_IRQ_RES_OVR]  = irq_stat_nxt[ADCST_IRQ_RES_OVR] |
                                       set_res_ovr;
  end

  // Sticky status bits
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_stat_r <= ADCST_RST_IRQ;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Mask bits; a one lets the event through
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_mask_r <= ADCST_RST_IRQ;
    end else if (wr_hit(wr_en, widx, ADCST_IDX_IRQ_MASK)) begin
      irq_mask_r <= pwdata_i[2:0];
    end
  end

  // Level output from registered state only
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // =====================================================================
  // Read mux
  // Registers hold eight bits at most;
  // upper bits and unmapped indices read zero
  always_comb begin
    rd_word = ADCST_RST_WORD;
    case (widx)
      ADCST_IDX_STATUS: begin
        // Bit 6 is wired to zero
        // Bits 3:0 always show the counter
        rd_word[7:0] = {sequence_done_flag_r, 1'b0,
                        trigger_overrun_flag_r, result_overrun_flag_r,
                        conv_cnt_r[3:0]};
      end
      ADCST_IDX_TEST0:    rd_word[7:0] = test0_r;
      // Top two bits carry no meaning and read zero here
      ADCST_IDX_TEST1:    rd_word[7:0] = {2'b00, test1_spare_r,
                                          special_en_r};
      ADCST_IDX_IRQ_STAT: rd_word[2:0] = irq_stat_r;
      ADCST_IDX_IRQ_MASK: rd_word[2:0] = irq_mask_r;
      ADCST_IDX_CONFIG:   rd_word[2:0] = config_r;
      default:            rd_word = ADCST_RST_WORD;
    endcase
  end

  // Captured in the setup cycle so the data comes from a flop
  // Keeps the access phase at one cycle with
  // no comb path from registers to prdata
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      prdata_o <= ADCST_RST_WORD;
    end else if (rd_setup) begin
      prdata_o <= mapped ? rd_word : ADCST_RST_WORD;
    end
  end

endmodule

// ---- adcst_status_regs_sva.sv ----
// Port checker for the converter status and test register block
`timescale 1ns/1ps
module adcst_status_regs_chk
  import adcst_pkg::*;
#(
  parameter int CNT_W = 4                      // Counter width
) (
  input wire logic             clk_sys_i,      // System clock
  input wire logic             resetn_i,       // Synchronous, low
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [11:0]      paddr_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             seq_start_trig_i,
  input wire logic             seq_end_i,
  input wire logic             result_write_i,
  input wire logic             ctrl_abort_wr_i,
  input wire logic             ctrl_start_wr_i,
  input wire logic [3:0]       chan_sel_i,
  input wire logic [CNT_W-1:0] conversion_counter_o,
  input wire logic             special_channel_enable_o,
  input wire logic             queue_mode_o,
  input wire adcst_src_type    chan_src_o
);
  // ====================
  // Helper terms
  wire ctl_wr   = ctrl_abort_wr_i | ctrl_start_wr_i;     // Any control write
  wire seq_edge = seq_end_i | seq_start_trig_i;          // Sequence bounds
  // Read setup to the status word; data is captured on this edge
  wire stat_rd  = psel_i & !penable_i & !pwrite_i &
                  (paddr_i == {2'b00, ADCST_IDX_STATUS, 2'b00});
  // Only three special codes name a real source
  wire spec_ok  = (chan_sel_i[3:2] == 2'b01) && (chan_sel_i[1:0] != 2'b11);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // ====================
  // Counter behaviour
  ctr_step_a: assert property (
    result_write_i && !ctl_wr && (queue_mode_o || !seq_edge) |=>
    conversion_counter_o == $past(conversion_counter_o) + 1'b1)
    else $error("counter did not step by one");
  ctr_hold_a: assert property (
    !result_write_i && !ctl_wr && (queue_mode_o || !seq_edge) |=>
    $stable(conversion_counter_o)) else $error("counter moved");
  ctr_ctl_a: assert property (ctl_wr |=> conversion_counter_o == 0)
    else $error("control write kept counter");
  ctr_seq_a: assert property (
    !queue_mode_o && seq_edge |=> conversion_counter_o == 0)
    else $error("sequence bound kept counter");
  // Status word layout as seen on the bus
  stat_word_a: assert property (stat_rd |=>
    prdata_o[31:8] == 24'h0 && !prdata_o[6] &&
    prdata_o[3:0] == $past(conversion_counter_o))
    else $error("status read word wrong");
  // ====================
  // Channel source decode
  src_off_a: assert property (
    !special_channel_enable_o |-> chan_src_o == ADCST_SRC_EXTERNAL)
    else $error("source remapped while disabled");
  src_code_a: assert property (
    special_channel_enable_o && spec_ok |->
    chan_src_o == {1'b0, chan_sel_i[1:0] + 2'b01})
    else $error("special code decoded wrong");
  src_rsvd_a: assert property (
    special_channel_enable_o && !spec_ok |->
    chan_src_o == ADCST_SRC_RESERVED) else $error("reserved code missed");

  cover property (result_write_i && conversion_counter_o == 4'hf);
  cover property (ctrl_abort_wr_i && queue_mode_o);
  cover property (special_channel_enable_o && spec_ok);
endmodule

bind adcst_status_regs adcst_status_regs_chk #(.CNT_W(CNT_W)) u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .seq_start_trig_i(seq_start_trig_i),
  .seq_end_i(seq_end_i), .result_write_i(result_write_i),
  .ctrl_abort_wr_i(ctrl_abort_wr_i), .ctrl_start_wr_i(ctrl_start_wr_i),
  .chan_sel_i(chan_sel_i), .conversion_counter_o(conversion_counter_o),
  .special_channel_enable_o(special_channel_enable_o),
  .queue_mode_o(queue_mode_o), .chan_src_o(chan_src_o));

// ---- tb_adc_status_and_test_regs.sv ----
// Self-checking bench for the converter status and test registers
`timescale 1ns/1ps
module tb_adc_status_and_test_regs;
  import adcst_pkg::*;
  // ====================
  // Stimulus and observed signals
  logic          clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i;
  logic          result_ccf_set_i, seq_active_i, special_mode_i;
  logic [11:0]   paddr_i;
  logic [31:0]   pwdata_i, prdata_o, rd_word;  // Bus data, last read
  logic [3:0]    chan_sel_i, conversion_counter_o;
  logic [6:0]    ev;                           // One-cycle event pulses
  logic          pready_o, pslverr_o, last_err, irq_o, spec_en;
  logic [7:0]    test0_o;
  logic          ffc, tls, qmode;
  adcst_src_type chan_src_o;
  int            error_cnt, comparisons;
  // Event bit masks, one per sequence controller pulse
  localparam logic [6:0] E_TRIG = 7'h01, E_END = 7'h02, E_EDGE = 7'h04,
    E_WRITE = 7'h08, E_RREAD = 7'h10, E_ABORT = 7'h20, E_START = 7'h40;

  adcst_status_regs #(.CNT_W(4)) u_adcst_status_regs (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .prdata_o(prdata_o), .seq_start_trig_i(ev[0]), .seq_end_i(ev[1]),
    .seq_active_i(seq_active_i), .trig_edge_i(ev[2]),
    .result_write_i(ev[3]), .result_ccf_set_i(result_ccf_set_i),
    .result_read_i(ev[4]), .ctrl_abort_wr_i(ev[5]),
    .ctrl_start_wr_i(ev[6]), .chan_sel_i(chan_sel_i),
    .special_mode_i(special_mode_i),
    .conversion_counter_o(conversion_counter_o),
    .special_channel_enable_o(spec_en), .fast_flag_clear_o(ffc),
    .trigger_level_select_o(tls), .queue_mode_o(qmode),
    .chan_src_o(chan_src_o),
    .test0_o(test0_o), .irq_o(irq_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // ====================
  // Shared tasks
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e,
                     input string what);
    comparisons++;
    if (got !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, e);
    end
  endtask

  // One APB transfer; the slave may stretch the access phase
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i   <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i  <= {2'b00, idx, 2'b00};
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys_i);
      if (pready_o === 1'b1) break;
    end
    rd_word  = prdata_o;
    last_err = pslverr_o;
    psel_i   <= 1'b0;
    penable_i <= 1'b0;
    if (n == 16) begin
      chk(32'h0, 32'h1, "bus timeout");
      results();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e,
                    input string what);
    apb(1'b0, idx, 32'h0);
    chk(rd_word, e, what);
  endtask

  // Pulse chosen events for exactly one cycle
  task automatic pulse(input logic [6:0] m);
    @(posedge clk_sys_i);
    ev <= m;
    @(posedge clk_sys_i);
    ev <= 7'h00;
  endtask

  // ====================
  // Scenarios
  task automatic t_reset;
    rd(ADCST_IDX_STATUS, 32'h0, "status reset");
    rd(ADCST_IDX_TEST1, 32'h0, "test1 reset");
    rd(8'h3f, 32'h0, "unmapped read");
    chk({31'h0, last_err}, 32'h1, "unmapped error");
    $display("reset test done");
  endtask

  task automatic t_done;
    wr(ADCST_IDX_IRQ_MASK, 32'h1);
    pulse(E_END);
    rd(ADCST_IDX_STATUS, 32'h80, "done set");
    chk({31'h0, irq_o}, 32'h1, "irq raised");
    rd(ADCST_IDX_IRQ_STAT, 32'h1, "irq status");
    wr(ADCST_IDX_STATUS, 32'h80);
    rd(ADCST_IDX_STATUS, 32'h0, "done cleared by one");
    wr(ADCST_IDX_IRQ_STAT, 32'h1);
    @(posedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
    pulse(E_END);
    pulse(E_END);
    rd(ADCST_IDX_STATUS, 32'h80, "done set again");
    pulse(E_START);
    rd(ADCST_IDX_STATUS, 32'h0, "done cleared by start");
    pulse(E_END);
    pulse(E_RREAD);
    rd(ADCST_IDX_STATUS, 32'h80, "read keeps done");
    wr(ADCST_IDX_CONFIG, 32'h1);
    rd(ADCST_IDX_CONFIG, 32'h1, "cfg read");
    pulse(E_RREAD);
    chk({29'h0, qmode, tls, ffc}, 32'h1, "cfg out");
    rd(ADCST_IDX_STATUS, 32'h0, "fast clear by read");
    wr(ADCST_IDX_IRQ_MASK, 32'h0);
    @(posedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    wr(ADCST_IDX_IRQ_STAT, 32'h7);
    $display("done flag test done");
  endtask

  task automatic t_trig;
    wr(ADCST_IDX_CONFIG, 32'h0);
    seq_active_i <= 1'b1;
    pulse(E_EDGE);
    rd(ADCST_IDX_STATUS, 32'h20, "trigger overrun");
    pulse(E_ABORT);
    rd(ADCST_IDX_STATUS, 32'h0, "overrun cleared by abort");
    pulse(E_EDGE);
    wr(ADCST_IDX_STATUS, 32'h20);
    rd(ADCST_IDX_STATUS, 32'h0, "overrun cleared by one");
    pulse(E_EDGE);
    pulse(E_START);
    rd(ADCST_IDX_STATUS, 32'h0, "overrun cleared by start");
    wr(ADCST_IDX_CONFIG, 32'h2);
    pulse(E_EDGE);
    chk({29'h0, qmode, tls, ffc}, 32'h2, "cfg out");
    rd(ADCST_IDX_STATUS, 32'h0, "level mode no overrun");
    wr(ADCST_IDX_CONFIG, 32'h0);
    seq_active_i <= 1'b0;
    pulse(E_EDGE);
    rd(ADCST_IDX_STATUS, 32'h0, "idle edge no overrun");
    $display("trigger overrun test done");
  endtask

  task automatic t_res;
    result_ccf_set_i <= 1'b1;
    pulse(E_WRITE);
    rd(ADCST_IDX_STATUS, 32'h11, "result overrun");
    pulse(E_TRIG);
    rd(ADCST_IDX_STATUS, 32'h0, "trigger start clears");
    pulse(E_WRITE);
    wr(ADCST_IDX_STATUS, 32'h10);
    rd(ADCST_IDX_STATUS, 32'h01, "overrun cleared by one");
    pulse(E_WRITE);
    pulse(E_START);
    rd(ADCST_IDX_STATUS, 32'h0, "start write clears");
    result_ccf_set_i <= 1'b0;
    pulse(E_WRITE);
    rd(ADCST_IDX_STATUS, 32'h01, "no overrun when read");
    $display("result overrun test done");
  endtask

  task automatic t_count;
    wr(ADCST_IDX_CONFIG, 32'h4);
    repeat (14) pulse(E_WRITE);
    chk({29'h0, qmode, tls, ffc}, 32'h4, "cfg out");
    rd(ADCST_IDX_STATUS, 32'h0f, "counter at maximum");
    pulse(E_TRIG);
    pulse(E_END);
    rd(ADCST_IDX_STATUS, 32'h8f, "queue keeps counter");
    wr(ADCST_IDX_STATUS, 32'hc0);
    rd(ADCST_IDX_STATUS, 32'h0f, "write keeps counter");
    pulse(E_WRITE);
    rd(ADCST_IDX_STATUS, 32'h0, "counter wraps");
    pulse(E_WRITE);
    pulse(E_ABORT);
    rd(ADCST_IDX_STATUS, 32'h0, "abort clears in queue");
    wr(ADCST_IDX_CONFIG, 32'h0);
    pulse(E_WRITE);
    pulse(E_END);
    rd(ADCST_IDX_STATUS, 32'h80, "end zeroes counter");
    wr(ADCST_IDX_STATUS, 32'h80);
    $display("counter test done");
  endtask

  task automatic t_test;
    int i;
    logic [31:0] e;
    wr(ADCST_IDX_TEST0, 32'h5a);
    @(posedge clk_sys_i);
    chk({24'h0, test0_o}, 32'h0, "test0 write ignored");
    special_mode_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    wr(ADCST_IDX_TEST0, 32'h5a);
    @(posedge clk_sys_i);
    chk({24'h0, test0_o}, 32'h5a, "test0 written");
    special_mode_i <= 1'b0;
    wr(ADCST_IDX_TEST1, 32'hd5);
    rd(ADCST_IDX_TEST1, 32'h15, "test1 readback");
    chk({31'h0, spec_en}, 32'h1, "special enable");
    for (i = 0; i < 16; i++) begin
      chan_sel_i <= 4'(i);
      @(posedge clk_sys_i);
      e = (i >= 4 && i <= 6) ? 32'(i - 3) : 32'h4;
      chk({29'h0, chan_src_o}, e, "special decode");
    end
    wr(ADCST_IDX_TEST1, 32'h0);
    @(posedge clk_sys_i);
    chk({29'h0, chan_src_o}, 32'h0, "special disabled");
    $display("test register test done");
  endtask

  // ====================
  // Main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, result_ccf_set_i} = '0;
    {seq_active_i, special_mode_i, ev, chan_sel_i} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    resetn_i = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset();
    t_done();
    t_trig();
    t_res();
    t_count();
    t_test();
    results();
  end
endmodule
